// ===== shared/mise_pkg.sv
// Constants and types for the instruction subset execution block
package mise_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int PC_W = 13;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int FILE_DEPTH = 128;
  localparam int WDT_W = 8;
  localparam int PRE_W = 8;
  // Operation selector at the instruction port
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_LOAD_LIT = 3'h1;
  localparam logic [2:0] OP_STORE = 3'h2;
  localparam logic [2:0] OP_RET_LIT = 3'h3;
  localparam logic [2:0] OP_RET_SUB = 3'h4;
  localparam logic [2:0] OP_RET_IRQ = 3'h5;
  localparam logic [2:0] OP_ROT_LEFT = 3'h6;
  localparam logic [2:0] OP_SLEEP = 3'h7;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  localparam logic [SP_W-1:0] SP_STEP = 3'h1;
  localparam logic [WDT_W-1:0] WDT_CLEAR = 8'h00;
  localparam logic [PRE_W-1:0] PRE_CLEAR = 8'h00;
  localparam logic [WDT_W-1:0] WDT_STEP = 8'h01;
  localparam logic [PRE_W-1:0] PRE_STEP = 8'h01;
  localparam int MSB = DATA_W - 1;

  typedef enum logic [2:0] {
    MISE_RUN = 3'b001,
    MISE_FLUSH = 3'b010,
    MISE_ASLEEP = 3'b100
  } mise_state_t;

  typedef struct packed {
    mise_state_t state;
    logic [DATA_W-1:0] acc;
    logic [PC_W-1:0] pc;
    logic [SP_W-1:0] sp;
    logic carry;
    logic power_down_n;
    logic timeout_n;
    logic irq_en;
    logic [WDT_W-1:0] wdt;
    logic [PRE_W-1:0] pre;
    logic busy;
    logic ready;
    logic halted;
    logic [DATA_W-1:0] rd;
  } mise_regs_t;
endpackage : mise_pkg

// ===== rtl/mise_core.sv
// Executes an eight-instruction subset of an 8-bit core
// Contract
// (RULE_01) Literal load copies the 8-bit immediate into accumulator; flags unchanged.
// (RULE_02) Zero don't-care bits in the literal-load word are accepted.
// (RULE_03) Store writes accumulator to the 7-bit addressed file register; flags unchanged.
// (RULE_04) Return-with-literal loads accumulator, pops stack into counter; two cycles.
// (RULE_05) Return pops stack head into counter in two cycles; flags unchanged.
// (RULE_06) Rotate-left through carry: old carry to bit 0, bit 7 to carry.
// (RULE_07) Rotate destination select 0 writes accumulator, 1 writes file register.
// (RULE_08) Sleep clears the watchdog counter and its prescaler.
// (RULE_09) Sleep clears power-down flag, sets timeout flag, nothing else.
// (RULE_10) After sleep the core halts; execution stops until wake.
// (RULE_11) Return-from-interrupt pops head into counter and sets interrupt enable.
// (RULE_12) No-operation takes one cycle and only advances the counter.
`timescale 1ns/100ps
`default_nettype none
module mise_core
  import mise_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Instruction port
  input wire logic instr_valid,
  input wire logic [2:0] instr_op,
  input wire logic [mise_pkg::DATA_W-1:0] instr_literal,
  input wire logic [mise_pkg::ADDR_W-1:0] instr_addr,
  input wire logic instr_dest,
  // Call push and wake
  input wire logic push_valid,
  input wire logic [mise_pkg::PC_W-1:0] push_addr,
  input wire logic wake,
  // State outputs
  output logic instr_ready,
  output logic [mise_pkg::DATA_W-1:0] acc,
  output logic [mise_pkg::PC_W-1:0] program_counter,
  output logic carry,
  output logic power_down_flag,
  output logic timeout_flag,
  output logic global_irq_enable,
  output logic [mise_pkg::WDT_W-1:0] watchdog_counter,
  output logic [mise_pkg::PRE_W-1:0] watchdog_prescaler,
  output logic osc_halted,
  output logic [mise_pkg::DATA_W-1:0] file_rd_data
);
  import mise_pkg::*;

  mise_regs_t r;
  mise_regs_t next_r;
  logic [DATA_W-1:0] file_mem [FILE_DEPTH];
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [SP_W-1:0] pop_sp;
  logic [DATA_W-1:0] file_val;
  logic [DATA_W-1:0] rot_val;
  logic file_we;
  logic [DATA_W-1:0] file_wd;
  logic [PC_W-1:0] popped_pc;
  logic [2:0] wake_sync;
  logic wake_seen;
  logic take;
  logic push_ok;

  // Returns pop the stack and need a second cycle
  function automatic logic pops_stack(input logic [2:0] op);
    pops_stack = (op == OP_RET_LIT) || (op == OP_RET_SUB) || (op == OP_RET_IRQ);
  endfunction : pops_stack

  // Wake pin passes three flops; level moves once last two agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_sync <= 3'h0;
      wake_seen <= 1'b0;
    end else begin
      wake_sync <= {wake_sync[1:0], wake};
      if (wake_sync[1] == wake_sync[2]) begin
        wake_seen <= wake_sync[2];
      end
    end
  end

  assign pop_sp = r.sp - SP_STEP;
  assign popped_pc = stack_mem[pop_sp];
  assign file_val = file_mem[instr_addr];
  assign rot_val = {file_val[MSB-1:0], r.carry}; // RULE_06
  assign take = instr_valid && (r.state == MISE_RUN) && !r.busy;
  // A push meeting a return is dropped so the pop reads a settled stack
  assign push_ok = push_valid && (r.state == MISE_RUN) && !(take && pops_stack(instr_op));

  always_comb begin
    next_r = r;
    file_we = 1'b0;
    file_wd = r.acc;
    next_r.busy = 1'b0;
    if (r.state != MISE_ASLEEP) begin
      next_r.wdt = r.wdt + WDT_STEP;
      next_r.pre = r.pre + PRE_STEP;
    end
    if (push_ok) begin
      next_r.sp = r.sp + SP_STEP;
    end
    case (r.state)
      MISE_RUN: begin
        if (take) begin
          next_r.pc = r.pc + PC_STEP;
          case (instr_op)
            OP_NOP: begin
              next_r.pc = r.pc + PC_STEP; // RULE_12
            end
            OP_LOAD_LIT: begin
              next_r.acc = instr_literal; // RULE_01 RULE_02
            end
            OP_STORE: begin
              file_we = 1'b1; // RULE_03
              file_wd = r.acc;
            end
            OP_RET_LIT: begin
              next_r.acc = instr_literal; // RULE_04
              next_r.pc = popped_pc;
            end
            OP_RET_SUB: begin
              next_r.pc = popped_pc; // RULE_05
            end
            OP_RET_IRQ: begin
              next_r.pc = popped_pc; // RULE_11
              next_r.irq_en = 1'b1;
            end
            OP_ROT_LEFT: begin
              next_r.carry = file_val[MSB]; // RULE_06
              if (instr_dest) begin
                file_we = 1'b1; // RULE_07
                file_wd = rot_val;
              end else begin
                next_r.acc = rot_val; // RULE_07
              end
            end
            OP_SLEEP: begin
              next_r.wdt = WDT_CLEAR; // RULE_08
              next_r.pre = PRE_CLEAR;
              next_r.power_down_n = 1'b0; // RULE_09
              next_r.timeout_n = 1'b1;
              next_r.state = MISE_ASLEEP; // RULE_10
            end
            default: begin
              next_r.pc = r.pc + PC_STEP;
            end
          endcase
          // Every return pops one entry and then idles a cycle
          if (pops_stack(instr_op)) begin
            next_r.sp = pop_sp; // RULE_04 RULE_05 RULE_11
            next_r.state = MISE_FLUSH;
          end
        end
      end
      MISE_FLUSH: begin
        // Second cycle of a return; fetched word is discarded
        next_r.state = MISE_RUN; // RULE_04 RULE_05
      end
      MISE_ASLEEP: begin
        if (wake_seen) begin
          next_r.state = MISE_RUN;
        end
      end
      default: begin
        next_r.state = MISE_RUN;
      end
    endcase
    // Read-back port holds the last word written
    if (file_we) begin
      next_r.rd = file_wd;
    end
    next_r.busy = (next_r.state != MISE_RUN);
    next_r.ready = (next_r.state == MISE_RUN);
    next_r.halted = (next_r.state == MISE_ASLEEP);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r.state <= MISE_RUN;
      r.acc <= ACC_RESET;
      r.pc <= PC_RESET;
      r.sp <= '0;
      r.carry <= 1'b0;
      r.power_down_n <= 1'b1;
      r.timeout_n <= 1'b1;
      r.irq_en <= 1'b0;
      r.wdt <= WDT_CLEAR;
      r.pre <= PRE_CLEAR;
      r.busy <= 1'b0;
      r.ready <= 1'b1;
      r.halted <= 1'b0;
      r.rd <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Storage arrays have no reset
  always_ff @(posedge clk) begin
    if (file_we) begin
      file_mem[instr_addr] <= file_wd;
    end
    if (push_ok) begin
      stack_mem[r.sp] <= push_addr;
    end
  end

  // Every output is a register field
  assign instr_ready = r.ready;
  assign acc = r.acc;
  assign program_counter = r.pc;
  assign carry = r.carry;
  assign power_down_flag = r.power_down_n;
  assign timeout_flag = r.timeout_n;
  assign global_irq_enable = r.irq_en;
  assign watchdog_counter = r.wdt;
  assign watchdog_prescaler = r.pre;
  assign osc_halted = r.halted;
  assign file_rd_data = r.rd;
endmodule : mise_core
`default_nettype wire

// ===== verif/mise_core_props.sv
// Port assertions for the execution block
`timescale 1ns/100ps
`default_nettype none
module mise_core_props
  import mise_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Instruction port
  input wire logic instr_valid,
  input wire logic [2:0] instr_op,
  input wire logic [mise_pkg::DATA_W-1:0] instr_literal,
  input wire logic instr_dest,
  // Observed state
  input wire logic instr_ready,
  input wire logic [mise_pkg::DATA_W-1:0] acc,
  input wire logic [mise_pkg::PC_W-1:0] program_counter,
  input wire logic carry,
  input wire logic power_down_flag,
  input wire logic timeout_flag,
  input wire logic global_irq_enable,
  input wire logic [mise_pkg::WDT_W-1:0] watchdog_counter,
  input wire logic [mise_pkg::PRE_W-1:0] watchdog_prescaler,
  input wire logic osc_halted,
  input wire logic [mise_pkg::DATA_W-1:0] file_rd_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic tk = instr_valid && instr_ready;
  sequence s_bubble;
    !instr_ready ##1 instr_ready;
  endsequence
  AST_NOP: assert property (tk && instr_op == OP_NOP |=> $stable(acc) &&
    program_counter == $past(program_counter) + PC_STEP) else $error("nop");
  AST_LOAD: assert property (tk && instr_op == OP_LOAD_LIT |=>
    acc == $past(instr_literal) && $stable(carry)) else $error("load");
  AST_STORE: assert property (tk && instr_op == OP_STORE |=>
    file_rd_data == $past(acc) && $stable(carry)) else $error("store");
  AST_RETLIT: assert property (tk && instr_op == OP_RET_LIT |=>
    acc == $past(instr_literal) ##0 s_bubble) else $error("retlit");
  AST_RET: assert property (tk && instr_op == OP_RET_SUB |=>
    $stable(carry) ##0 s_bubble) else $error("ret");
  AST_ROT: assert property (tk && instr_op == OP_ROT_LEFT |=>
    ($past(instr_dest) ? file_rd_data[0] : acc[0]) == $past(carry)) else $error("rot");
  AST_SLEEP: assert property (tk && instr_op == OP_SLEEP |=> osc_halted &&
    watchdog_counter == WDT_CLEAR && watchdog_prescaler == PRE_CLEAR) else $error("sleep");
  AST_FLAGS: assert property (tk && instr_op == OP_SLEEP |=>
    !power_down_flag && timeout_flag) else $error("flags");
  AST_HALT: assert property (osc_halted |-> !instr_ready) else $error("halt");
  AST_RETIRQ: assert property (tk && instr_op == OP_RET_IRQ |=>
    global_irq_enable) else $error("retirq");
endmodule : mise_core_props
bind mise_core mise_core_props u_props (
  .clk(clk),
  .rst_n(rst_n),
  .instr_valid(instr_valid),
  .instr_op(instr_op),
  .instr_literal(instr_literal),
  .instr_dest(instr_dest),
  .instr_ready(instr_ready),
  .acc(acc),
  .program_counter(program_counter),
  .carry(carry),
  .power_down_flag(power_down_flag),
  .timeout_flag(timeout_flag),
  .global_irq_enable(global_irq_enable),
  .watchdog_counter(watchdog_counter),
  .watchdog_prescaler(watchdog_prescaler),
  .osc_halted(osc_halted),
  .file_rd_data(file_rd_data)
);
`default_nettype wire

// ===== verif/mise_core_tb_top.sv
// Self-checking bench for the execution block
`timescale 1ns/100ps
`default_nettype none
module mise_core_tb_top;
  import mise_pkg::*;
  logic clk, rst_n, instr_valid, instr_dest, push_valid, wake, instr_ready, carry, tk;
  logic power_down_flag, timeout_flag, global_irq_enable, osc_halted;
  logic [2:0] instr_op;
  logic [6:0] instr_addr;
  logic [7:0] instr_literal, acc, watchdog_counter, watchdog_prescaler, file_rd_data, k;
  logic [12:0] push_addr, program_counter;
  logic [15:0] got;
  logic [18:0] q[$];
  int fail_count = 0, n_checks = 0, seed = 44, cyc = 0;
  mise_core dut (
    .clk(clk),
    .rst_n(rst_n),
    .instr_valid(instr_valid),
    .instr_op(instr_op),
    .instr_literal(instr_literal),
    .instr_addr(instr_addr),
    .instr_dest(instr_dest),
    .push_valid(push_valid),
    .push_addr(push_addr),
    .wake(wake),
    .instr_ready(instr_ready),
    .acc(acc),
    .program_counter(program_counter),
    .carry(carry),
    .power_down_flag(power_down_flag),
    .timeout_flag(timeout_flag),
    .global_irq_enable(global_irq_enable),
    .watchdog_counter(watchdog_counter),
    .watchdog_prescaler(watchdog_prescaler),
    .osc_halted(osc_halted),
    .file_rd_data(file_rd_data)
  );
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    tk <= instr_valid && instr_ready;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      summarize();
    end
  end
  always @(negedge clk) if (tk === 1'b1) begin
    case (q[0][18:16])
      3'h0: got = 16'(acc);
      3'h1: got = 16'(program_counter);
      3'h2: got = 16'(carry);
      3'h3: got = 16'(file_rd_data);
      3'h4: got = 16'({global_irq_enable, power_down_flag, timeout_flag});
      3'h6: got = {acc, 5'h00, power_down_flag, timeout_flag, osc_halted};
      default: got = {watchdog_counter, watchdog_prescaler};
    endcase
    n_checks++;
    if (got !== q[0][15:0]) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", sel_name(q[0][18:16]), q[0][15:0], got);
    end
    void'(q.pop_front());
  end
  // Rotate destination rides on literal bit 0
  task automatic ex(input logic [2:0] o, input logic [7:0] l, input logic [6:0] a,
    input logic [2:0] s, input logic [15:0] e);
    q.push_back({s, e});
    instr_valid <= 1'b1;
    {instr_op, instr_literal, instr_addr, instr_dest} <= {o, l, a, l[0]};
    do @(negedge clk); while (instr_ready !== 1'b1);
    @(posedge clk);
  endtask : ex
  function automatic string sel_name(input logic [2:0] s);
    case (s)
      3'h0: sel_name = "acc";
      3'h1: sel_name = "program_counter";
      3'h2: sel_name = "carry";
      3'h3: sel_name = "file_rd_data";
      3'h4: sel_name = "irq_enable_and_flags";
      3'h6: sel_name = "acc_and_flags";
      default: sel_name = "watchdog_and_prescaler";
    endcase
  endfunction : sel_name
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  initial begin
    {rst_n, instr_valid, instr_op, instr_literal, instr_addr, instr_dest} = '0;
    {push_valid, push_addr, wake} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ex(OP_NOP, 8'h00, 7'h00, 3'h1, 16'h0001);
    ex(OP_LOAD_LIT, 8'h00, 7'h00, 3'h0, 16'h0000);
    repeat (8) begin
      k = 8'($random(seed));
      ex(OP_LOAD_LIT, k, 7'h00, 3'h0, {8'h00, k});
      ex(OP_STORE, 8'h00, k[6:0], 3'h3, {8'h00, k});
    end
    ex(OP_LOAD_LIT, 8'hff, 7'h00, 3'h0, 16'h00ff);
    ex(OP_STORE, 8'h00, 7'h7f, 3'h3, 16'h00ff);
    $display("done load store");
    ex(OP_ROT_LEFT, 8'h01, 7'h7f, 3'h3, 16'h00fe);
    ex(OP_NOP, 8'h00, 7'h00, 3'h2, 16'h0001);
    ex(OP_ROT_LEFT, 8'h00, 7'h7f, 3'h0, 16'h00fd);
    $display("done rotate");
    instr_valid <= 1'b0;
    push_valid <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      push_addr <= 13'h0123 << i;
      @(posedge clk);
    end
    push_valid <= 1'b0;
    ex(OP_RET_SUB, 8'h00, 7'h00, 3'h1, 16'h048c);
    ex(OP_RET_LIT, 8'h5a, 7'h00, 3'h0, 16'h005a);
    ex(OP_NOP, 8'h00, 7'h00, 3'h1, 16'h0247);
    ex(OP_RET_IRQ, 8'h00, 7'h00, 3'h4, 16'h0007);
    $display("done returns");
    ex(OP_SLEEP, 8'h00, 7'h00, 3'h5, 16'h0000);
    fork
      ex(OP_NOP, 8'h00, 7'h00, 3'h6, 16'h5a02);
      begin
        repeat (10) @(posedge clk);
        wake <= 1'b1;
      end
    join
    instr_valid <= 1'b0;
    wake <= 1'b0;
    $display("done sleep");
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule : mise_core_tb_top
`default_nettype wire
